// [dfm_pkg.sv]
package dfm_pkg;

   // ****************************************
   // Parameter addresses
   // ****************************************
   localparam logic [15:0] ADDR_CLASS_SEL  = 16'h0516;
   localparam logic [15:0] ADDR_PS_WARN    = 16'h100c;
   localparam logic [15:0] ADDR_PS_MAX     = 16'h100e;
   localparam logic [15:0] ADDR_PEAK       = 16'h111e;
   localparam logic [15:0] ADDR_MAX_DIFF   = 16'h121c;
   localparam logic [15:0] ADDR_SIG_CUR    = 16'h1c0e;
   localparam logic [15:0] ADDR_SIG_SAVED  = 16'h1c10;
   localparam logic [15:0] ADDR_WARN_ACT   = 16'h1c16;
   localparam logic [15:0] ADDR_WARN_SAVED = 16'h1c18;
   localparam logic [15:0] ADDR_PS_TEMP    = 16'h1c20;
   localparam logic [15:0] ADDR_OVL_NOW    = 16'h1c32;
   localparam logic [15:0] ADDR_LOAD_MEAN  = 16'h1c34;
   localparam logic [15:0] ADDR_DEV_NOW    = 16'h1e24;

   // ****************************************
   // Fixed limits and settings
   // ****************************************
   localparam logic signed [15:0] PS_TEMP_WARN = 16'sh0055;
   localparam logic signed [15:0] PS_TEMP_MAX  = 16'sh005f;
   localparam logic signed [15:0] M_TEMP_WARN  = 16'sh0073;
   localparam logic signed [15:0] M_TEMP_MAX   = 16'sh0082;
   localparam logic signed [15:0] I2T_LIMIT    = 16'sh0064;
   localparam logic [31:0] MAX_DIFF_MIN   = 32'h0000_0001;
   localparam logic [31:0] MAX_DIFF_RESET = 32'h0000_2710;
   localparam logic [31:0] MAX_DIFF_MAX   = 32'h001e_8480;
   localparam logic [1:0]  CLASS_MIN      = 2'h1;
   localparam logic [1:0]  CLASS_MAX      = 2'h3;
   localparam logic [1:0]  CLASS_RESET    = 2'h3;

   // ****************************************
   // Timing
   // ****************************************
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned OVERTEMP_TIME_S = 5;
   localparam int unsigned TICK_TIME_MS    = 1;
   localparam int unsigned OVERTEMP_CYCLES = OVERTEMP_TIME_S * CLK_HZ;
   localparam int unsigned TICK_CYCLES     = TICK_TIME_MS * (CLK_HZ / 1000);

   // ****************************************
   // Monitoring and warning bit positions
   // ****************************************
   localparam int SIG_LIMIT_SW   = 1;
   localparam int SIG_STO_LOW    = 4;
   localparam int SIG_OVERTEMP   = 21;
   localparam int SIG_TRACKING   = 22;
   localparam int SIG_STO_DIFF   = 24;
   localparam logic [31:0] SIG_RESERVED = 32'h1e00_2820;
   localparam logic [31:0] SIG_OWN      = 32'h0160_0012;
   localparam int WARN_PS_TEMP   = 1;
   localparam int WARN_M_TEMP    = 2;
   localparam int WARN_PS_I2T    = 4;
   localparam int WARN_M_I2T     = 5;
   localparam logic [15:0] WARN_RESERVED = 16'h8008;
   localparam logic [15:0] WARN_OWN      = 16'h0036;
   localparam logic [15:0] WARN_SELF_CLR = 16'h2c00;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic [15:0] addr;
      logic        wr;
      logic        rd;
      logic [31:0] wdata;
   } dfm_par_req_type;

   typedef struct packed {
      logic       power_stage_enable;
      logic       controller_on;
      logic       stop;
      logic       current_nominal;
      logic [1:0] error_class;
   } dfm_drive_ctrl_type;

endpackage

// [dfm_persist_timer.sv]
module dfm_persist_timer #(
   parameter int unsigned LIMIT = 200_000_000
) (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic above,
   output logic      expired
);
   import dfm_pkg::*;

   logic [31:0] count_q;
   logic [31:0] count_d;
   logic        at_limit;

   // Counter saturates so a long excursion never wraps back to zero
   assign at_limit = (count_q == LIMIT);
   assign count_d  = !above ? 32'h0000_0000 : (at_limit ? count_q : count_q + 32'h0000_0001);
   // Time above the limit has gone past the full span
   assign expired  = above && at_limit;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= 32'h0000_0000;
      end else begin
         count_q <= count_d;
      end
   end

endmodule

// [dfm_monitor.sv]
module dfm_monitor #(
   parameter int unsigned OVERTEMP_CYCLES_P = dfm_pkg::OVERTEMP_CYCLES,
   parameter int unsigned TICK_CYCLES_P     = dfm_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic                        CLOCK_IN,
   input  wire logic                        RESET_N_IN,
   // Parameter access from fieldbus side
   input  wire dfm_pkg::dfm_par_req_type    PAR_REQ_IN,
   output logic [31:0]                      PAR_RDATA_OUT,
   output logic                             PAR_ACK_OUT,
   output logic                             PAR_ERR_OUT,
   // Fault reset
   input  wire logic                        FAULT_CLEAR_COMMAND_IN,
   // Pins
   input  wire logic [1:0]                  SAFE_TORQUE_OFF_INPUTS_IN,
   input  wire logic                        POSITIVE_LIMIT_SWITCH_N_IN,
   input  wire logic                        NEGATIVE_LIMIT_SWITCH_N_IN,
   // Measurements
   input  wire logic signed [15:0]          POWER_STAGE_TEMP_IN,
   input  wire logic signed [15:0]          MOTOR_TEMP_IN,
   input  wire logic signed [15:0]          POWER_STAGE_I2T_IN,
   input  wire logic signed [15:0]          MOTOR_OVERLOAD_NOW_IN,
   input  wire logic signed [15:0]          MOTOR_LOAD_MEAN_IN,
   input  wire logic signed [31:0]          REF_POSITION_IN,
   input  wire logic signed [31:0]          ACT_POSITION_IN,
   // Conditions from other monitors
   input  wire logic [31:0]                 SIGNAL_OTHER_IN,
   input  wire logic [15:0]                 WARN_OTHER_IN,
   // Drive control
   output dfm_pkg::dfm_drive_ctrl_type      DRIVE_CTRL_OUT,
   output logic [31:0]                      MONITOR_SIGNALS_CURRENT_OUT,
   output logic [15:0]                      WARNINGS_ACTIVE_OUT
);
   import dfm_pkg::*;

   function automatic logic [31:0] magnitude(input logic signed [31:0] v);
      magnitude = v[31] ? (32'h0000_0000 - 32'(v)) : 32'(v);
   endfunction

   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [3:0] pin_meta_q;
   logic [3:0] pin_sync_q;

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         pin_meta_q <= 4'hf;
         pin_sync_q <= 4'hf;
      end else begin
         pin_meta_q <= {SAFE_TORQUE_OFF_INPUTS_IN, POSITIVE_LIMIT_SWITCH_N_IN,
                        NEGATIVE_LIMIT_SWITCH_N_IN};
         pin_sync_q <= pin_meta_q;
      end
   end

   logic limit_hit;
   logic sto_low;
   logic sto_diff;

   // Limit switches are normally closed, so an open wire also reads as hit
   assign limit_hit = !pin_sync_q[1] || !pin_sync_q[0];
   assign sto_low   = !pin_sync_q[3] || !pin_sync_q[2];
   assign sto_diff  = pin_sync_q[3] ^ pin_sync_q[2];

   // ****************************************
   // Temperature
   // ****************************************
   logic ps_warn;
   logic m_warn;
   logic ps_above;
   logic m_above;
   logic ps_expired;
   logic m_expired;
   logic temp_err_q;
   logic temp_err_d;

   assign ps_warn  = POWER_STAGE_TEMP_IN >= PS_TEMP_WARN;
   assign m_warn   = MOTOR_TEMP_IN >= M_TEMP_WARN;
   assign ps_above = POWER_STAGE_TEMP_IN > PS_TEMP_MAX;
   assign m_above  = MOTOR_TEMP_IN > M_TEMP_MAX;

   dfm_persist_timer #(
      .LIMIT (OVERTEMP_CYCLES_P)
   ) u_ps_timer (
      .clk     (CLOCK_IN),
      .rst_n   (RESET_N_IN),
      .above   (ps_above),
      .expired (ps_expired)
   );

   dfm_persist_timer #(
      .LIMIT (OVERTEMP_CYCLES_P)
   ) u_m_timer (
      .clk     (CLOCK_IN),
      .rst_n   (RESET_N_IN),
      .above   (m_above),
      .expired (m_expired)
   );

   // Set wins over a fault reset in the same cycle
   assign temp_err_d = ps_expired || m_expired || (temp_err_q && !FAULT_CLEAR_COMMAND_IN);

   // ****************************************
   // I2t
   // ****************************************
   logic ps_i2t_over;
   logic m_i2t_over;
   logic nominal_q;

   assign ps_i2t_over = POWER_STAGE_I2T_IN > I2T_LIMIT;
   assign m_i2t_over  = MOTOR_OVERLOAD_NOW_IN > I2T_LIMIT;

   // ****************************************
   // Following error
   // ****************************************
   logic [15:0]        tick_cnt_q;
   logic               tick;
   logic signed [31:0] dev_d;
   logic signed [31:0] dev_q;
   logic [31:0]        dev_mag;
   logic [31:0]        peak_q;
   logic [31:0]        max_diff_q;
   logic [1:0]         class_q;
   logic               follow_err_q;
   logic               follow_trip;
   logic               follow_err_d;

   assign tick        = (tick_cnt_q == 16'(TICK_CYCLES_P - 1));
   assign dev_d       = REF_POSITION_IN - ACT_POSITION_IN;
   assign dev_mag     = magnitude(dev_d);
   assign follow_trip = tick && (dev_mag > max_diff_q);
   // Set wins over a fault reset in the same cycle
   assign follow_err_d = follow_trip || (follow_err_q && !FAULT_CLEAR_COMMAND_IN);

   // ****************************************
   // Monitoring and warning words
   // ****************************************
   logic [31:0] sig_own;
   logic [31:0] sig_cur_d;
   logic [31:0] sig_cur_q;
   logic [31:0] sig_saved_q;
   logic [15:0] warn_own;
   logic [15:0] warn_act_d;
   logic [15:0] warn_act_q;
   logic [15:0] warn_saved_q;
   logic [15:0] warn_keep;
   logic [31:0] sig_latch_mask;
   logic [31:0] sig_set;

   always_comb begin
      sig_own               = 32'h0000_0000;
      sig_own[SIG_LIMIT_SW] = limit_hit;
      sig_own[SIG_STO_LOW]  = sto_low;
      sig_own[SIG_OVERTEMP] = temp_err_q;
      sig_own[SIG_TRACKING] = follow_err_q;
      sig_own[SIG_STO_DIFF] = sto_diff;
      warn_own              = 16'h0000;
      warn_own[WARN_PS_TEMP] = ps_warn;
      warn_own[WARN_M_TEMP]  = m_warn;
      warn_own[WARN_PS_I2T]  = ps_i2t_over;
      warn_own[WARN_M_I2T]   = m_i2t_over;
   end

   assign sig_cur_d  = ((SIGNAL_OTHER_IN & ~SIG_OWN) | sig_own) & ~SIG_RESERVED;
   assign warn_act_d = ((WARN_OTHER_IN & ~WARN_OWN) | warn_own) & ~WARN_RESERVED;
   // Self-clearing warnings follow the active word instead of holding
   assign warn_keep  = FAULT_CLEAR_COMMAND_IN ? 16'h0000 : (warn_saved_q & ~WARN_SELF_CLR);
   // Latched errors enter the saved word from their next value: the current word
   // still shows them in the clearing cycle and would store them straight back
   assign sig_latch_mask = (32'h0000_0001 << SIG_OVERTEMP) | (32'h0000_0001 << SIG_TRACKING);
   assign sig_set        = (sig_cur_d & ~sig_latch_mask) | (32'(temp_err_d) << SIG_OVERTEMP)
                        | (32'(follow_err_d) << SIG_TRACKING);

   // ****************************************
   // Parameter access decode
   // ****************************************
   logic        hit_class;
   logic        hit_peak;
   logic        hit_max_diff;
   logic        hit_ro;
   logic        wr_class_ok;
   logic        wr_max_ok;
   logic        wr_peak;
   logic        wr_bad;
   logic        rd_bad;
   logic [31:0] rd_mux;

   assign hit_class    = PAR_REQ_IN.addr == ADDR_CLASS_SEL;
   assign hit_peak     = PAR_REQ_IN.addr == ADDR_PEAK;
   assign hit_max_diff = PAR_REQ_IN.addr == ADDR_MAX_DIFF;
   assign hit_ro       = (PAR_REQ_IN.addr == ADDR_PS_WARN) || (PAR_REQ_IN.addr == ADDR_PS_MAX)
                      || (PAR_REQ_IN.addr == ADDR_SIG_CUR) || (PAR_REQ_IN.addr == ADDR_SIG_SAVED)
                      || (PAR_REQ_IN.addr == ADDR_WARN_ACT) || (PAR_REQ_IN.addr == ADDR_WARN_SAVED)
                      || (PAR_REQ_IN.addr == ADDR_PS_TEMP) || (PAR_REQ_IN.addr == ADDR_OVL_NOW)
                      || (PAR_REQ_IN.addr == ADDR_LOAD_MEAN) || (PAR_REQ_IN.addr == ADDR_DEV_NOW);
   assign wr_peak      = PAR_REQ_IN.wr && hit_peak;
   assign wr_max_ok    = PAR_REQ_IN.wr && hit_max_diff && (PAR_REQ_IN.wdata >= MAX_DIFF_MIN)
                      && (PAR_REQ_IN.wdata <= MAX_DIFF_MAX);
   assign wr_class_ok  = PAR_REQ_IN.wr && hit_class && (PAR_REQ_IN.wdata[31:0] >= 32'(CLASS_MIN))
                      && (PAR_REQ_IN.wdata[31:0] <= 32'(CLASS_MAX));
   // Writes to read-only, unmapped or out-of-range values change nothing
   assign wr_bad       = PAR_REQ_IN.wr && !wr_peak && !wr_max_ok && !wr_class_ok;
   assign rd_bad       = PAR_REQ_IN.rd && !(hit_ro || hit_class || hit_peak || hit_max_diff);

   always_comb begin
      unique case (PAR_REQ_IN.addr)
         ADDR_CLASS_SEL:  rd_mux = {30'h0, class_q};
         ADDR_PS_WARN:    rd_mux = {16'h0000, PS_TEMP_WARN};
         ADDR_PS_MAX:     rd_mux = {16'h0000, PS_TEMP_MAX};
         ADDR_PEAK:       rd_mux = peak_q;
         ADDR_MAX_DIFF:   rd_mux = max_diff_q;
         ADDR_SIG_CUR:    rd_mux = sig_cur_q;
         ADDR_SIG_SAVED:  rd_mux = sig_saved_q;
         ADDR_WARN_ACT:   rd_mux = {16'h0000, warn_act_q};
         ADDR_WARN_SAVED: rd_mux = {16'h0000, warn_saved_q};
         ADDR_PS_TEMP:    rd_mux = {16'h0000, POWER_STAGE_TEMP_IN};
         ADDR_OVL_NOW:    rd_mux = {16'h0000, MOTOR_OVERLOAD_NOW_IN};
         ADDR_LOAD_MEAN:  rd_mux = {16'h0000, MOTOR_LOAD_MEAN_IN};
         ADDR_DEV_NOW:    rd_mux = dev_q;
         default:         rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         temp_err_q   <= 1'b0;
         nominal_q    <= 1'b0;
         follow_err_q <= 1'b0;
      end else begin
         temp_err_q   <= temp_err_d;
         nominal_q    <= ps_i2t_over || m_i2t_over;
         follow_err_q <= follow_err_d;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         tick_cnt_q   <= 16'h0000;
         dev_q        <= 32'sh0000_0000;
         peak_q       <= 32'h0000_0000;
         max_diff_q   <= MAX_DIFF_RESET;
         class_q      <= CLASS_RESET;
      end else begin
         tick_cnt_q   <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
         if (tick) begin
            dev_q <= dev_d;
         end
         // A new peak on a tick wins over a clearing write
         if (tick && (dev_mag > peak_q)) begin
            peak_q <= dev_mag;
         end else if (wr_peak) begin
            peak_q <= 32'h0000_0000;
         end
         if (wr_max_ok) begin
            max_diff_q <= PAR_REQ_IN.wdata;
         end
         if (wr_class_ok) begin
            class_q <= PAR_REQ_IN.wdata[1:0];
         end
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         sig_cur_q    <= 32'h0000_0000;
         sig_saved_q  <= 32'h0000_0000;
         warn_act_q   <= 16'h0000;
         warn_saved_q <= 16'h0000;
      end else begin
         sig_cur_q    <= sig_cur_d;
         sig_saved_q  <= (FAULT_CLEAR_COMMAND_IN ? 32'h0000_0000 : sig_saved_q) | sig_set;
         warn_act_q   <= warn_act_d;
         warn_saved_q <= warn_keep | warn_act_d;
      end
   end

   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         PAR_RDATA_OUT <= 32'h0000_0000;
         PAR_ACK_OUT   <= 1'b0;
         PAR_ERR_OUT   <= 1'b0;
      end else begin
         PAR_ACK_OUT   <= PAR_REQ_IN.wr || PAR_REQ_IN.rd;
         PAR_ERR_OUT   <= wr_bad || rd_bad;
         if (PAR_REQ_IN.rd) begin
            PAR_RDATA_OUT <= rd_bad ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   assign DRIVE_CTRL_OUT.power_stage_enable = !temp_err_q;
   assign DRIVE_CTRL_OUT.controller_on      = !temp_err_q;
   assign DRIVE_CTRL_OUT.stop               = follow_err_q;
   assign DRIVE_CTRL_OUT.current_nominal    = nominal_q;
   assign DRIVE_CTRL_OUT.error_class        = class_q;
   assign MONITOR_SIGNALS_CURRENT_OUT       = sig_cur_q;
   assign WARNINGS_ACTIVE_OUT               = warn_act_q;

endmodule

// [dfm_monitor_asserts.sv]
module dfm_monitor_asserts
   import dfm_pkg::*;
#(
   parameter int unsigned OVERTEMP_CYCLES_P = 20,
   parameter int unsigned TICK_CYCLES_P     = 8
) (
   // Clock and reset
   input wire logic                 CLOCK_IN,
   input wire logic                 RESET_N_IN,
   // Watched inputs
   input wire dfm_par_req_type      PAR_REQ_IN,
   input wire logic                 FAULT_CLEAR_COMMAND_IN,
   input wire logic [1:0]           SAFE_TORQUE_OFF_INPUTS_IN,
   input wire logic signed [15:0]   POWER_STAGE_TEMP_IN,
   input wire logic signed [15:0]   MOTOR_TEMP_IN,
   input wire logic signed [15:0]   POWER_STAGE_I2T_IN,
   input wire logic signed [15:0]   MOTOR_OVERLOAD_NOW_IN,
   // Watched outputs
   input wire logic                 PAR_ACK_OUT,
   input wire logic                 PAR_ERR_OUT,
   input wire dfm_drive_ctrl_type   DRIVE_CTRL_OUT,
   input wire logic [31:0]          MONITOR_SIGNALS_CURRENT_OUT,
   input wire logic [15:0]          WARNINGS_ACTIVE_OUT
);
   logic [31:0] ps_cnt_q;
   logic [31:0] m_cnt_q;
   wire         ps_hot = POWER_STAGE_TEMP_IN > PS_TEMP_MAX;
   wire         m_hot  = MOTOR_TEMP_IN > M_TEMP_MAX;
   wire         req = PAR_REQ_IN.wr || PAR_REQ_IN.rd;
   wire  [31:0] wd  = PAR_REQ_IN.wdata;

   // ****************************************
   // Consecutive overtemperature cycles per sensor, each with its own timer
   // ****************************************
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ps_cnt_q <= '0;
         m_cnt_q  <= '0;
      end else begin
         ps_cnt_q <= !ps_hot ? '0 : (ps_cnt_q == '1 ? ps_cnt_q : ps_cnt_q + 32'h1);
         m_cnt_q  <= !m_hot ? '0 : (m_cnt_q == '1 ? m_cnt_q : m_cnt_q + 32'h1);
      end
   end

   default clocking cb @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);

   ack_after_req_a: assert property (req |=> PAR_ACK_OUT) else $error("ack missing");
   ack_only_req_a: assert property (!req |=> !PAR_ACK_OUT) else $error("stray ack");
   err_with_ack_a: assert property (PAR_ERR_OUT |-> PAR_ACK_OUT) else $error("err alone");
   ro_write_err_a: assert property (PAR_REQ_IN.wr && (PAR_REQ_IN.addr == ADDR_PS_WARN ||
      PAR_REQ_IN.addr == ADDR_PS_MAX) |=> PAR_ERR_OUT) else $error("limit write taken");
   limit_range_err_a: assert property (PAR_REQ_IN.wr && PAR_REQ_IN.addr == ADDR_MAX_DIFF &&
      (wd < MAX_DIFF_MIN || wd > MAX_DIFF_MAX) |=> PAR_ERR_OUT) else $error("range taken");
   class_out_a: assert property (PAR_REQ_IN.wr && PAR_REQ_IN.addr == ADDR_CLASS_SEL &&
      wd >= 32'(CLASS_MIN) && wd <= 32'(CLASS_MAX) |=> DRIVE_CTRL_OUT.error_class == $past(wd[1:0]))
      else $error("class not applied");
   ps_warn_a: assert property (1'b1 |=> WARNINGS_ACTIVE_OUT[WARN_PS_TEMP] ==
      ($past(POWER_STAGE_TEMP_IN) >= PS_TEMP_WARN)) else $error("temp warning wrong");
   i2t_limit_a: assert property (1'b1 |=> DRIVE_CTRL_OUT.current_nominal ==
      ($past(POWER_STAGE_I2T_IN) > I2T_LIMIT || $past(MOTOR_OVERLOAD_NOW_IN) > I2T_LIMIT))
      else $error("current limit wrong");
   trip_early_a: assert property ($fell(DRIVE_CTRL_OUT.power_stage_enable) |->
      ps_cnt_q > OVERTEMP_CYCLES_P || m_cnt_q > OVERTEMP_CYCLES_P) else $error("trip too early");
   trip_late_a: assert property (ps_cnt_q >= OVERTEMP_CYCLES_P + 3 ||
      m_cnt_q >= OVERTEMP_CYCLES_P + 3 |->
      !DRIVE_CTRL_OUT.power_stage_enable && !DRIVE_CTRL_OUT.controller_on) else $error("no trip");
   stop_holds_a: assert property (DRIVE_CTRL_OUT.stop && !FAULT_CLEAR_COMMAND_IN |=>
      DRIVE_CTRL_OUT.stop) else $error("stop dropped");
   tracking_bit_a: assert property (DRIVE_CTRL_OUT.stop |=>
      MONITOR_SIGNALS_CURRENT_OUT[SIG_TRACKING]) else $error("tracking bit missing");
   inputs_low_a: assert property ((SAFE_TORQUE_OFF_INPUTS_IN == 2'h0) [*4] |=>
      MONITOR_SIGNALS_CURRENT_OUT[SIG_STO_LOW]) else $error("inputs low bit missing");
   inputs_differ_a: assert property ((SAFE_TORQUE_OFF_INPUTS_IN == 2'h1) [*4] |=>
      MONITOR_SIGNALS_CURRENT_OUT[SIG_STO_DIFF]) else $error("inputs differ bit missing");
endmodule

bind dfm_monitor dfm_monitor_asserts #(
   .OVERTEMP_CYCLES_P(OVERTEMP_CYCLES_P),
   .TICK_CYCLES_P    (TICK_CYCLES_P)
) u_asserts (
   .CLOCK_IN(CLOCK_IN), .RESET_N_IN(RESET_N_IN), .PAR_REQ_IN(PAR_REQ_IN),
   .FAULT_CLEAR_COMMAND_IN(FAULT_CLEAR_COMMAND_IN),
   .SAFE_TORQUE_OFF_INPUTS_IN(SAFE_TORQUE_OFF_INPUTS_IN),
   .POWER_STAGE_TEMP_IN(POWER_STAGE_TEMP_IN), .MOTOR_TEMP_IN(MOTOR_TEMP_IN),
   .POWER_STAGE_I2T_IN(POWER_STAGE_I2T_IN), .MOTOR_OVERLOAD_NOW_IN(MOTOR_OVERLOAD_NOW_IN),
   .PAR_ACK_OUT(PAR_ACK_OUT), .PAR_ERR_OUT(PAR_ERR_OUT), .DRIVE_CTRL_OUT(DRIVE_CTRL_OUT),
   .MONITOR_SIGNALS_CURRENT_OUT(MONITOR_SIGNALS_CURRENT_OUT),
   .WARNINGS_ACTIVE_OUT(WARNINGS_ACTIVE_OUT)
);

// [dfm_master_model.sv]
module dfm_master_model
   import dfm_pkg::*;
(
   // Clock and bus
   input  wire logic        clk_in,
   input  wire logic        ack_in,
   input  wire logic        err_in,
   input  wire logic [31:0] rdata_in,
   output dfm_par_req_type  req_out
);
   timeunit 1ns;
   timeprecision 100ps;

   initial req_out = '0;

   // ****************************************
   // One access: raise after a falling edge, answer taken one cycle later
   // ****************************************
   task automatic xfer(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e, output logic k);
      @(negedge clk_in);
      req_out <= '{addr: a, wr: w, rd: !w, wdata: d};
      @(negedge clk_in);
      q = rdata_in;
      e = err_in;
      k = ack_in;
      // Idle fields scrambled so the design cannot lean on stale values
      req_out <= '{addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
   endtask
endmodule

// [dfm_monitor_tb_top.sv]
`define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin errors++; \
   $display("CHECK FAILED %s exp %0h got %0h", nm, ex, gt); end end

module dfm_monitor_tb_top
   import dfm_pkg::*;
();
   timeunit 1ns;
   timeprecision 100ps;

   logic               clk = 1'b0, rst_n = 1'b0, clr = 1'b0, lim_p_n = 1'b1, lim_n_n = 1'b1;
   logic [1:0]         safe_torque_off_inputs = 2'h3;
   logic signed [15:0] ps_t = 16'sh0019, m_t = 16'sh0019, ps_i2t = '0, m_ovl = 16'sh0064;
   logic signed [15:0] m_mean = 16'sh0042;
   logic signed [31:0] ref_p = '0, act_p = '0;
   logic [31:0]        sig_other = '0, rdata, sig_cur, q, lim [4];
   logic [15:0]        warn_other = '0, warn_act;
   logic               ack, err, e, k;
   dfm_par_req_type    req;
   dfm_drive_ctrl_type ctrl;
   int                 errors = 0, cmp_count = 0;

   always #12.5 clk = ~clk;

   dfm_master_model m (.clk_in(clk), .ack_in(ack), .err_in(err), .rdata_in(rdata), .req_out(req));

   dfm_monitor #(.OVERTEMP_CYCLES_P(20), .TICK_CYCLES_P(8)) uut (
      .CLOCK_IN(clk), .RESET_N_IN(rst_n), .PAR_REQ_IN(req), .PAR_RDATA_OUT(rdata),
      .PAR_ACK_OUT(ack), .PAR_ERR_OUT(err), .FAULT_CLEAR_COMMAND_IN(clr),
      .SAFE_TORQUE_OFF_INPUTS_IN(safe_torque_off_inputs), .POSITIVE_LIMIT_SWITCH_N_IN(lim_p_n),
      .NEGATIVE_LIMIT_SWITCH_N_IN(lim_n_n), .POWER_STAGE_TEMP_IN(ps_t), .MOTOR_TEMP_IN(m_t),
      .POWER_STAGE_I2T_IN(ps_i2t), .MOTOR_OVERLOAD_NOW_IN(m_ovl), .MOTOR_LOAD_MEAN_IN(m_mean),
      .REF_POSITION_IN(ref_p), .ACT_POSITION_IN(act_p), .SIGNAL_OTHER_IN(sig_other),
      .WARN_OTHER_IN(warn_other), .DRIVE_CTRL_OUT(ctrl), .MONITOR_SIGNALS_CURRENT_OUT(sig_cur),
      .WARNINGS_ACTIVE_OUT(warn_act));

   // ****************************************
   // Access, wait and report helpers
   // ****************************************
   task automatic acc(input logic w, input logic [15:0] a, input logic [31:0] d,
                      input logic [31:0] ex, input logic e_ex);
      m.xfer(w, a, d, q, e, k);
      `CHK("ack", 1'b1, k)
      `CHK("err", e_ex, e)
      if (!w) `CHK("rdata", ex, q)
   endtask

   task automatic step(input int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic fault_clear();
      clr = 1'b1;
      step(1);
      clr = 1'b0;
      step(3);
   endtask

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      lim = '{32'h0, 32'h001e_8481, 32'h001e_8480, 32'h1};
      step(2);
      rst_n = 1'b1;
      acc(0, ADDR_PS_WARN, 0, {16'h0, PS_TEMP_WARN}, 0);
      acc(0, ADDR_PS_MAX, 0, {16'h0, PS_TEMP_MAX}, 0);
      acc(0, ADDR_MAX_DIFF, 0, MAX_DIFF_RESET, 0);
      acc(0, ADDR_CLASS_SEL, 0, 32'h3, 0);
      acc(0, ADDR_SIG_SAVED, 0, 32'h0, 0);
      acc(1, ADDR_PS_WARN, 32'h0, 0, 1);
      acc(0, ADDR_PS_WARN, 0, {16'h0, PS_TEMP_WARN}, 0);
      acc(1, ADDR_SIG_CUR, 32'h1, 0, 1);
      acc(0, 16'h0000, 0, 32'h0, 1);
      acc(0, ADDR_LOAD_MEAN, 0, 32'h42, 0);
      acc(0, ADDR_OVL_NOW, 0, 32'h64, 0);
      for (int i = 0; i < 4; i++) begin
         acc(1, ADDR_MAX_DIFF, lim[i], 0, i < 2);
         acc(0, ADDR_MAX_DIFF, 0, i < 2 ? MAX_DIFF_RESET : lim[i], 0);
         if (i < 2) continue;
      end
      for (int c = 0; c < 4; c++) begin
         acc(1, ADDR_CLASS_SEL, c, 0, c == 0);
         `CHK("class", c == 0 ? 2'h3 : 2'(c), ctrl.error_class)
      end
      $display("test registers done");
      acc(1, ADDR_MAX_DIFF, 32'd100, 0, 0);
      ref_p = 32'sd1000;
      act_p = 32'sd950;
      step(10);
      acc(0, ADDR_DEV_NOW, 0, 32'd50, 0);
      acc(0, ADDR_PEAK, 0, 32'd50, 0);
      `CHK("stop", 1'b0, ctrl.stop)
      act_p = 32'sd1150;
      for (int i = 0; i < 12 && ctrl.stop !== 1'b1; i++) step(1);
      if (ctrl.stop !== 1'b1) begin
         errors++;
         wrap_up();
      end
      act_p = 32'sd1000;
      step(2);
      `CHK("tracking bit", 1'b1, sig_cur[SIG_TRACKING])
      acc(0, ADDR_PEAK, 0, 32'd150, 0);
      step(10);
      acc(0, ADDR_DEV_NOW, 0, 32'd0, 0);
      `CHK("stop held", 1'b1, ctrl.stop)
      acc(1, ADDR_PEAK, 32'h5, 0, 0);
      acc(0, ADDR_PEAK, 0, 32'd0, 0);
      fault_clear();
      `CHK("stop clear", 1'b0, ctrl.stop)
      acc(0, ADDR_SIG_SAVED, 0, 32'h0, 0);
      $display("test tracking done");
      ps_t = PS_TEMP_WARN;
      m_t = M_TEMP_WARN;
      step(2);
      `CHK("warnings", 16'h0006, warn_act)
      `CHK("enable", 1'b1, ctrl.power_stage_enable)
      ps_t = -16'sd5;
      m_t = M_TEMP_WARN - 16'sd1;
      step(2);
      `CHK("no warning", 16'h0, warn_act)
      acc(0, ADDR_PS_TEMP, 0, 32'h0000_fffb, 0);
      acc(0, ADDR_WARN_SAVED, 0, 32'h6, 0);
      ps_t = PS_TEMP_MAX + 16'sd1;
      step(18);
      `CHK("short heat", 1'b1, ctrl.power_stage_enable)
      step(10);
      `CHK("heat trip", 2'b00, {ctrl.power_stage_enable, ctrl.controller_on})
      `CHK("overtemp bit", 1'b1, sig_cur[SIG_OVERTEMP])
      ps_t = 16'sh0019;
      m_ovl = '0;
      ps_i2t = I2T_LIMIT + 16'sd1;
      fault_clear();
      `CHK("heat clear", 1'b1, ctrl.power_stage_enable)
      `CHK("i2t over", 1'b1, ctrl.current_nominal)
      ps_i2t = I2T_LIMIT;
      step(2);
      `CHK("i2t under", 1'b0, ctrl.current_nominal)
      $display("test temperature done");
      safe_torque_off_inputs = 2'h0;
      step(5);
      `CHK("inputs low", 1'b1, sig_cur[SIG_STO_LOW])
      safe_torque_off_inputs = 2'h1;
      lim_p_n = 1'b0;
      step(5);
      `CHK("differ", 2'b11, {sig_cur[SIG_STO_DIFF], sig_cur[SIG_LIMIT_SW]})
      safe_torque_off_inputs = 2'h3;
      lim_p_n = 1'b1;
      lim_n_n = 1'b0;
      step(5);
      `CHK("one switch", 32'h2, sig_cur)
      lim_n_n = 1'b1;
      acc(0, ADDR_SIG_SAVED, 0, 32'h0100_0012, 0);
      fault_clear();
      acc(0, ADDR_SIG_SAVED, 0, 32'h0, 0);
      sig_other = '1;
      warn_other = '1;
      step(3);
      `CHK("others", ~(SIG_RESERVED | SIG_OWN), sig_cur)
      `CHK("other warn", ~(WARN_RESERVED | WARN_OWN), warn_act)
      sig_other = '0;
      warn_other = '0;
      step(3);
      acc(0, ADDR_SIG_SAVED, 0, ~(SIG_RESERVED | SIG_OWN), 0);
      acc(0, ADDR_WARN_SAVED, 0, {16'h0, ~(WARN_RESERVED | WARN_OWN | WARN_SELF_CLR)}, 0);
      fault_clear();
      acc(0, ADDR_SIG_SAVED, 0, 32'h0, 0);
      acc(0, ADDR_WARN_SAVED, 0, 32'h0, 0);
      $display("test signal words done");
      wrap_up();
   end
endmodule
